// *** shared/clk_ctrl_pkg.sv ***
// Constants, register layouts and state types for the clock source and PLL control block
package clk_ctrl_pkg;

	// ==========================================================
	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] OFS_MAIN_SEL = 4'h0;
	localparam logic [3:0] OFS_REF_SEL = 4'h1;
	localparam logic [3:0] OFS_WDT_SEL = 4'h2;
	localparam logic [3:0] OFS_OUT_SEL = 4'h3;
	localparam logic [3:0] OFS_PLL_CTRL = 4'h4;
	localparam logic [3:0] OFS_PLL_STAT = 4'h5;
	localparam logic [3:0] OFS_CORE_DIV = 4'h6;
	localparam logic [3:0] OFS_GATE = 4'h7;
	localparam logic [3:0] OFS_WDO_CTRL = 4'h8;
	localparam logic [3:0] OFS_OSC_CTRL = 4'h9;

	// ==========================================================
	// Frequencies and timing
	localparam int CLK_SYS_HZ = 40_000_000;
	localparam int IRC_NOMINAL_HZ = 12_000_000;
	localparam int PLL_SETTLE_US = 100;
	localparam int LOCK_CYCLES = PLL_SETTLE_US * (CLK_SYS_HZ / 1_000_000);
	localparam int LOCK_CNT_W = 12;

	// ==========================================================
	// Main clock sources, in selector order
	typedef enum logic [1:0] {SRC_IRC, SRC_PLL_IN, SRC_WDO, SRC_PLL_OUT} main_src_t;

	// PLL control: multiplier is field+1 (1..32), post divider is 2 << field
	typedef struct packed {
		logic [6:0] spare;
		logic bypass;
		logic enable;
		logic [1:0] post_div;
		logic [4:0] mult;
	} pll_ctrl_t;

	// Watchdog oscillator analog trim: frequency band and divide setting
	typedef struct packed {
		logic [4:0] div_sel;
		logic [3:0] freq_sel;
	} wdo_ctrl_t;

	// Oscillator pins, all from outside the clk_sys domain
	typedef struct packed {
		logic current_ctrl_osc;
		logic watchdog_osc;
		logic sys;
		logic internal_rc_osc;
	} osc_t;

	typedef struct packed {
		main_src_t main_sel;
		logic ref_sel;
		logic wdt_sel;
		logic [1:0] out_sel;
		pll_ctrl_t pll;
		logic [7:0] core_div;
		logic [DATA_W-1:0] gate;
		wdo_ctrl_t watchdog_osc;
		logic irc_pd;
	} regs_t;

	localparam pll_ctrl_t PLL_RST = '{spare: 7'h00, bypass: 1'b1, enable: 1'b0,
		post_div: 2'h0, mult: 5'h00};
	localparam wdo_ctrl_t WDO_RST = '{div_sel: 5'h00, freq_sel: 4'h1};
	localparam logic [7:0] CORE_DIV_RST = 8'h01;
	localparam logic [DATA_W-1:0] GATE_RST = 16'h001F;
	localparam regs_t REGS_RST = '{main_sel: SRC_IRC, ref_sel: 1'b0, wdt_sel: 1'b0,
		out_sel: 2'h0, pll: PLL_RST, core_div: CORE_DIV_RST, gate: GATE_RST,
		watchdog_osc: WDO_RST, irc_pd: 1'b0};

	// State of one glitch-free source selector
	typedef struct packed {
		logic [1:0] cur;
		logic out;
	} sw_state_t;

	localparam sw_state_t SW_RST = '{cur: 2'h0, out: 1'b0};

endpackage : clk_ctrl_pkg

// *** hdl/clk_switch.sv ***
// Glitch-free four-way selector for oversampled clock levels
`timescale 1ns/1ps

module clk_switch (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Source levels and selection
	input wire logic [3:0] src,
	input wire logic [1:0] sel,
	// Selected clock and the source now in use
	output logic clk_out,
	output logic [1:0] cur_sel
);

	clk_ctrl_pkg::sw_state_t s;
	clk_ctrl_pkg::sw_state_t next_s;

	// ==========================================================
	// Switch only while both old output and new source sit low
	always_comb begin
		next_s = s;
		if (sel != s.cur && !s.out && !src[sel]) begin
			next_s.cur = sel;
			next_s.out = 1'b0;
		end else begin
			next_s.out = src[s.cur];
		end
	end

	// A stopped old source left high holds the switch; keep sources running while in use
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= clk_ctrl_pkg::SW_RST;
		end else begin
			s <= next_s;
		end
	end

	assign clk_out = s.out;
	assign cur_sel = s.cur;

	// ==========================================================
	// A source change never cuts a high phase short
	a_switch_low_phase: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(s.cur) |-> !$past(s.out) && !s.out)
		else $error("selector changed source while output was high");

endmodule : clk_switch

// *** hdl/clock_source_pll_control.sv ***
// Clock source selection, PLL sequencing and clock output control
`timescale 1ns/1ps

module clock_source_pll_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port
	input wire logic [clk_ctrl_pkg::ADDR_W-1:0] addr,
	input wire logic [clk_ctrl_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [clk_ctrl_pkg::DATA_W-1:0] rdata,
	// Oscillator pins
	input wire clk_ctrl_pkg::osc_t osc_pins,
	// Selected clocks
	output logic main_clk,
	output logic watchdog_clock,
	output logic pll_ref_clk,
	output logic clock_output_pin,
	// Analog controls
	output logic pll_pd,
	output logic [4:0] pll_mult,
	output clk_ctrl_pkg::wdo_ctrl_t wdo_trim,
	output logic irc_pd,
	// Core and peripheral clocking
	output logic core_clk_en,
	output logic [clk_ctrl_pkg::DATA_W-1:0] periph_clk_en
);

	typedef struct packed {
		clk_ctrl_pkg::osc_t sync1;
		clk_ctrl_pkg::osc_t sync2;
		logic cco_prev;
		logic main_prev;
		clk_ctrl_pkg::regs_t regs;
		logic [clk_ctrl_pkg::DATA_W-1:0] rdata;
		logic [clk_ctrl_pkg::LOCK_CNT_W-1:0] lock_cnt;
		logic lock;
		logic [3:0] pdiv_cnt;
		logic pdiv;
		logic [7:0] core_cnt;
		logic core_en;
		logic pll_pd;
	} state_t;

	localparam state_t STATE_RST = '{sync1: '0, sync2: '0, cco_prev: 1'b0,
		main_prev: 1'b0, regs: clk_ctrl_pkg::REGS_RST, rdata: '0, lock_cnt: '0,
		lock: 1'b0, pdiv_cnt: 4'h0, pdiv: 1'b0, core_cnt: 8'h00, core_en: 1'b0,
		pll_pd: 1'b1};
	localparam logic [clk_ctrl_pkg::LOCK_CNT_W-1:0] LOCK_LAST =
		clk_ctrl_pkg::LOCK_CNT_W'(clk_ctrl_pkg::LOCK_CYCLES - 1);

	state_t s;
	state_t next_s;
	logic pll_out;
	logic cco_rise;
	logic main_rise;
	logic irc_used;
	logic pll_wr;
	clk_ctrl_pkg::main_src_t main_eff;
	logic [1:0] main_cur;
	logic [1:0] wdt_cur;
	logic [1:0] ref_cur;
	logic [1:0] out_cur;

	// ==========================================================
	// Helpers

	// Edges of the post divider between output toggles: 1, 2, 4 or 8
	function automatic logic [3:0] half_ratio(input logic [1:0] code);
		half_ratio = 4'h1 << code;
	endfunction : half_ratio

	// Write strobe aimed at one register
	function automatic logic hit(input logic strobe, input logic [3:0] a,
		input logic [3:0] ofs);
		hit = strobe && (a == ofs);
	endfunction : hit

	// Register settings under which some selector draws on the RC oscillator
	function automatic logic irc_needed(input clk_ctrl_pkg::regs_t r, input logic lk);
		irc_needed = r.main_sel == clk_ctrl_pkg::SRC_IRC ||
			(r.main_sel == clk_ctrl_pkg::SRC_PLL_OUT && !lk) || !r.ref_sel ||
			!r.wdt_sel || r.out_sel == 2'h0;
	endfunction : irc_needed

	// ==========================================================
	// Derived levels

	// Bypassed or unpowered PLL passes its reference straight through
	assign pll_out = (s.regs.pll.bypass || !s.regs.pll.enable) ? pll_ref_clk : s.pdiv;
	assign cco_rise = s.sync2.current_ctrl_osc && !s.cco_prev;
	assign main_rise = main_clk && !s.main_prev;
	assign pll_wr = hit(wr, addr, clk_ctrl_pkg::OFS_PLL_CTRL);

	// An unlocked PLL output is never handed to the main selector
	assign main_eff = (s.regs.main_sel == clk_ctrl_pkg::SRC_PLL_OUT && !s.lock) ?
		clk_ctrl_pkg::SRC_IRC : s.regs.main_sel;

	// The RC oscillator counts as in use by any selector set to reach it, or while the main selector still sits on it
	assign irc_used = irc_needed(s.regs, s.lock) || main_cur == 2'h0;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		// Two-stage synchronisers on every oscillator pin
		next_s.sync1 = osc_pins;
		next_s.sync2 = s.sync1;
		next_s.cco_prev = s.sync2.current_ctrl_osc;
		next_s.main_prev = main_clk;

		// Register writes
		if (wr) begin
			case (addr)
				clk_ctrl_pkg::OFS_MAIN_SEL: begin
					next_s.regs.main_sel = clk_ctrl_pkg::main_src_t'(wdata[1:0]);
				end
				clk_ctrl_pkg::OFS_REF_SEL: begin
					next_s.regs.ref_sel = wdata[0];
				end
				clk_ctrl_pkg::OFS_WDT_SEL: begin
					next_s.regs.wdt_sel = wdata[0];
				end
				clk_ctrl_pkg::OFS_OUT_SEL: begin
					next_s.regs.out_sel = wdata[1:0];
				end
				clk_ctrl_pkg::OFS_PLL_CTRL: begin
					next_s.regs.pll = clk_ctrl_pkg::pll_ctrl_t'(wdata);
					next_s.regs.pll.spare = '0;
				end
				clk_ctrl_pkg::OFS_CORE_DIV: begin
					next_s.regs.core_div = wdata[7:0];
				end
				clk_ctrl_pkg::OFS_GATE: begin
					next_s.regs.gate = wdata;
				end
				clk_ctrl_pkg::OFS_WDO_CTRL: begin
					next_s.regs.watchdog_osc = clk_ctrl_pkg::wdo_ctrl_t'(wdata[8:0]);
				end
				clk_ctrl_pkg::OFS_OSC_CTRL: begin
					next_s.regs.irc_pd = wdata[0];
				end
				default: begin
				end
			endcase
		end

		// Read data stands in the cycle after the strobe only
		next_s.rdata = '0;
		if (rd) begin
			case (addr)
				clk_ctrl_pkg::OFS_MAIN_SEL: next_s.rdata = {12'h000, main_cur, s.regs.main_sel};
				clk_ctrl_pkg::OFS_REF_SEL: next_s.rdata = {15'h0000, s.regs.ref_sel};
				clk_ctrl_pkg::OFS_WDT_SEL: next_s.rdata = {15'h0000, s.regs.wdt_sel};
				clk_ctrl_pkg::OFS_OUT_SEL: next_s.rdata = {14'h0000, s.regs.out_sel};
				clk_ctrl_pkg::OFS_PLL_CTRL: next_s.rdata = s.regs.pll;
				clk_ctrl_pkg::OFS_PLL_STAT: next_s.rdata = {15'h0000, s.lock};
				clk_ctrl_pkg::OFS_CORE_DIV: next_s.rdata = {8'h00, s.regs.core_div};
				clk_ctrl_pkg::OFS_GATE: next_s.rdata = s.regs.gate;
				clk_ctrl_pkg::OFS_WDO_CTRL: next_s.rdata = {7'h00, s.regs.watchdog_osc};
				clk_ctrl_pkg::OFS_OSC_CTRL: next_s.rdata = {15'h0000, s.regs.irc_pd};
				default: next_s.rdata = '0;
			endcase
		end

		// Lock timer restarts on power-off and on any reprogramming
		if (!s.regs.pll.enable || pll_wr) begin
			next_s.lock_cnt = '0;
			next_s.lock = 1'b0;
		end else if (s.lock_cnt == LOCK_LAST) begin
			next_s.lock = 1'b1;
		end else begin
			next_s.lock_cnt = s.lock_cnt + 1'b1;
		end

		// Power-down pin is its own flop, kept in step with the enable bit
		next_s.pll_pd = !next_s.regs.pll.enable;

		// RC power-down is refused while a selector is set to reach it, now or from the next edge, or while the main selector still sits on it;
		// looking ahead keeps the pin low in the very cycle a selector returns to RC
		if (irc_used || irc_needed(next_s.regs, next_s.lock)) begin
			next_s.regs.irc_pd = 1'b0;
		end

		// Post divider toggles after equal edge counts, so duty is exactly half
		if (!s.regs.pll.enable) begin
			next_s.pdiv_cnt = 4'h0;
			next_s.pdiv = 1'b0;
		end else if (cco_rise) begin
			if (s.pdiv_cnt >= half_ratio(s.regs.pll.post_div) - 4'h1) begin
				next_s.pdiv_cnt = 4'h0;
				next_s.pdiv = !s.pdiv;
			end else begin
				next_s.pdiv_cnt = s.pdiv_cnt + 4'h1;
			end
		end

		// Core clock enable: one pulse per core_div rising edges of main clock; zero stops it
		next_s.core_en = 1'b0;
		if (main_rise && s.regs.core_div != 8'h00) begin
			if (s.core_cnt >= s.regs.core_div - 8'h01) begin
				next_s.core_cnt = 8'h00;
				next_s.core_en = 1'b1;
			end else begin
				next_s.core_cnt = s.core_cnt + 8'h01;
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Glitch-free selectors; each output is the selector's own flop

	// PLL reference: RC oscillator or system oscillator
	clk_switch u_ref_sw (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.src({s.sync2.internal_rc_osc, s.sync2.internal_rc_osc, s.sync2.sys, s.sync2.internal_rc_osc}),
		.sel({1'b0, s.regs.ref_sel}),
		.clk_out(pll_ref_clk),
		.cur_sel(ref_cur)
	);

	// Main clock: RC, PLL reference, watchdog oscillator or locked PLL
	clk_switch u_main_sw (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.src({pll_out, s.sync2.watchdog_osc, pll_ref_clk, s.sync2.internal_rc_osc}),
		.sel(main_eff),
		.clk_out(main_clk),
		.cur_sel(main_cur)
	);

	// Watchdog timer clock: RC or watchdog oscillator
	clk_switch u_wdt_sw (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.src({s.sync2.internal_rc_osc, s.sync2.internal_rc_osc, s.sync2.watchdog_osc, s.sync2.internal_rc_osc}),
		.sel({1'b0, s.regs.wdt_sel}),
		.clk_out(watchdog_clock),
		.cur_sel(wdt_cur)
	);

	// Clock output pin: RC, system oscillator, watchdog oscillator or main clock
	clk_switch u_out_sw (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.src({main_clk, s.sync2.watchdog_osc, s.sync2.sys, s.sync2.internal_rc_osc}),
		.sel(s.regs.out_sel),
		.clk_out(clock_output_pin),
		.cur_sel(out_cur)
	);

	// ==========================================================
	// Register outputs
	assign rdata = s.rdata;
	assign pll_pd = s.pll_pd;
	assign pll_mult = s.regs.pll.mult;
	assign wdo_trim = s.regs.watchdog_osc;
	assign irc_pd = s.regs.irc_pd;
	assign core_clk_en = s.core_en;
	assign periph_clk_en = s.regs.gate;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_no_unlocked_pll: assert property (
		main_eff == clk_ctrl_pkg::SRC_PLL_OUT |-> s.lock && s.regs.pll.enable)
		else $error("PLL output offered to main clock before lock");

	a_lock_waits_settle: assert property (
		pll_wr |=> !s.lock [*8])
		else $error("lock reported too soon after PLL reprogramming");

	a_lock_count_exact: assert property (
		$rose(s.lock) |-> $past(s.lock_cnt) == LOCK_LAST)
		else $error("lock rose at the wrong count");

	a_pd_means_bypass: assert property (
		pll_pd |-> pll_out == pll_ref_clk && !s.lock)
		else $error("powered-down PLL not bypassed");

	a_irc_kept_alive: assert property (
		irc_pd |-> !irc_used && main_cur != 2'h0)
		else $error("RC oscillator powered down while in use");

	a_stat_reads_lock: assert property (
		rd && addr == clk_ctrl_pkg::OFS_PLL_STAT |=> rdata[0] == $past(s.lock))
		else $error("status read does not show lock");

	a_pdiv_on_edge: assert property (
		$changed(s.pdiv) && s.regs.pll.enable |-> $past(cco_rise))
		else $error("post divider toggled without an oscillator edge");

	a_read_one_cycle: assert property (
		!rd |=> rdata == '0)
		else $error("read data held past its cycle");

	a_core_en_cause: assert property (
		core_clk_en |-> $past(main_rise) && $past(s.regs.core_div) != 8'h00)
		else $error("core enable without main clock edge");

	a_irc_pd_refused: assert property (
		wr && addr == clk_ctrl_pkg::OFS_MAIN_SEL &&
		clk_ctrl_pkg::main_src_t'(wdata[1:0]) == clk_ctrl_pkg::SRC_IRC |=> !irc_pd)
		else $error("RC power-down kept after RC became the main source");

	a_core_en_single: assert property (
		core_clk_en |=> !core_clk_en)
		else $error("core enable held for more than one cycle");

endmodule : clock_source_pll_control

// *** dv/testbench.sv ***
// Self-checking bench for the clock source and PLL control block
`timescale 1ns/1ps

module testbench;
	// ==========================================================
	// Stimulus, observed outputs and bookkeeping
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [clk_ctrl_pkg::ADDR_W-1:0] addr = '0;
	logic [clk_ctrl_pkg::DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [clk_ctrl_pkg::DATA_W-1:0] rdata;
	logic [clk_ctrl_pkg::DATA_W-1:0] periph_clk_en;
	clk_ctrl_pkg::osc_t osc_pins = '0;
	clk_ctrl_pkg::wdo_ctrl_t wdo_trim;
	logic main_clk, watchdog_clock, pll_ref_clk, clock_output_pin;
	logic pll_pd, irc_pd, core_clk_en, rd_seen;
	logic [4:0] pll_mult, m;
	logic [4:0] taps;
	logic [15:0] d;
	logic [15:0] exp_q[$];
	int bad_count = 0;
	int total_checks = 0;
	int seed = 82446;
	int unsigned tick = 0;
	int out_per[4] = '{6, 8, 10, 6};

	assign taps = {core_clk_en, pll_ref_clk, watchdog_clock, clock_output_pin, main_clk};

	always #12.5 clk_sys = ~clk_sys;

	clock_source_pll_control dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .osc_pins(osc_pins), .main_clk(main_clk),
		.watchdog_clock(watchdog_clock), .pll_ref_clk(pll_ref_clk),
		.clock_output_pin(clock_output_pin), .pll_pd(pll_pd), .pll_mult(pll_mult),
		.wdo_trim(wdo_trim), .irc_pd(irc_pd), .core_clk_en(core_clk_en),
		.periph_clk_en(periph_clk_en)
	);

	// ==========================================================
	// Oscillator pins: distinct periods of 2, 6, 8 and 10 cycles tell sources apart
	always @(posedge clk_sys) begin
		tick <= tick + 1;
		osc_pins.current_ctrl_osc <= ~osc_pins.current_ctrl_osc;
		if (tick % 3 == 2) osc_pins.internal_rc_osc <= ~osc_pins.internal_rc_osc;
		if (tick % 4 == 3) osc_pins.sys <= ~osc_pins.sys;
		if (tick % 5 == 4) osc_pins.watchdog_osc <= ~osc_pins.watchdog_osc;
		// Whole run needs about 20k cycles; a hang is cut short well after that
		if (tick == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Read monitor: read data stand only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rd_seen === 1'b1) begin
			if (exp_q.size() == 0) bad_count++;
			else check(32'(rdata), 32'(exp_q.pop_front()));
		end
		rd_seen <= rd;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// A strobe is dropped one edge later, so back-to-back calls leave a one-cycle gap
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		rd <= 1'b0;
	endtask : reg_rd

	task automatic settle();
		repeat (40) @(posedge clk_sys);
	endtask : settle

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
	endtask : do_reset

	// Counts rising edges and high cycles of one tap; a runt pulse spoils both counts
	task automatic meas(input int which, input int n, input int e_edges, input int e_highs);
		int edges;
		int highs;
		logic prev;
		edges = 0;
		highs = 0;
		@(posedge clk_sys);
		prev = taps[which];
		repeat (n) begin
			@(posedge clk_sys);
			if (taps[which] === 1'b1 && prev === 1'b0) edges++;
			if (taps[which] === 1'b1) highs++;
			prev = taps[which];
		end
		check(32'(edges), 32'(e_edges));
		check(32'(highs), 32'(e_highs));
	endtask : meas

	// Ten whole periods: exactly ten rising edges and half the cycles high
	task automatic per(input int which, input int p);
		meas(which, 10 * p, 10, 5 * p);
	endtask : per

	// ==========================================================
	// Main sequence
	initial begin
		do_reset();
		check(32'(pll_pd), 32'h1);
		check(32'(periph_clk_en), 32'h1F);
		check(32'(wdo_trim), 32'h001);
		reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0000);
		reg_rd(clk_ctrl_pkg::OFS_PLL_CTRL, 16'h0100);
		reg_rd(clk_ctrl_pkg::OFS_PLL_STAT, 16'h0000);
		reg_rd(clk_ctrl_pkg::OFS_CORE_DIV, 16'h0001);
		reg_rd(clk_ctrl_pkg::OFS_GATE, 16'h001F);
		reg_rd(4'hC, 16'h0000);
		settle();
		per(0, 6);
		per(2, 6);
		per(3, 6);
		// Other sources for the watchdog timer and the PLL reference
		reg_wr(clk_ctrl_pkg::OFS_WDT_SEL, 16'h0001);
		reg_wr(clk_ctrl_pkg::OFS_REF_SEL, 16'h0001);
		settle();
		per(2, 10);
		per(3, 8);
		// PLL reference straight onto the main clock through selector input 1, around the PLL
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0001);
		settle();
		per(0, 8);
		reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0005);
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0000);
		settle();
		for (int k = 0; k < 4; k++) begin
			reg_wr(clk_ctrl_pkg::OFS_OUT_SEL, 16'(k));
			settle();
			per(1, out_per[k]);
		end
		// Power-down of the RC source is refused while the main selector is set to it, granted once no selector is, and undone when main returns to it
		reg_wr(clk_ctrl_pkg::OFS_OSC_CTRL, 16'h0001);
		settle();
		check(32'(irc_pd), 32'h0);
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0002);
		reg_wr(clk_ctrl_pkg::OFS_OUT_SEL, 16'h0001);
		settle();
		per(0, 10);
		reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h000A);
		reg_wr(clk_ctrl_pkg::OFS_OSC_CTRL, 16'h0001);
		settle();
		check(32'(irc_pd), 32'h1);
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0000);
		settle();
		check(32'(irc_pd), 32'h0);
		reg_wr(clk_ctrl_pkg::OFS_OSC_CTRL, 16'h0000);
		// PLL: every post divider, random multiplier, lock before connection
		reg_wr(clk_ctrl_pkg::OFS_OUT_SEL, 16'h0003);
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0003);
		for (int c = 0; c < 4; c++) begin
			m = 5'($random(seed));
			reg_wr(clk_ctrl_pkg::OFS_PLL_CTRL, {7'h00, 1'b0, 1'b1, 2'(c), m});
			settle();
			check(32'(pll_pd), 32'h0);
			check(32'(pll_mult), 32'(m));
			reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0003);
			per(0, 6);
			repeat (clk_ctrl_pkg::LOCK_CYCLES - 200) @(posedge clk_sys);
			reg_rd(clk_ctrl_pkg::OFS_PLL_STAT, 16'h0000);
			repeat (300) @(posedge clk_sys);
			reg_rd(clk_ctrl_pkg::OFS_PLL_STAT, 16'h0001);
			settle();
			reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h000F);
			per(0, 4 << c);
			per(1, 4 << c);
		end
		// Disabling the PLL drops lock and returns the main clock to the RC source
		reg_wr(clk_ctrl_pkg::OFS_PLL_CTRL, 16'h0100);
		settle();
		check(32'(pll_pd), 32'h1);
		reg_rd(clk_ctrl_pkg::OFS_PLL_STAT, 16'h0000);
		reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0003);
		// Gates, trim and core divider
		d = 16'($random(seed));
		reg_wr(clk_ctrl_pkg::OFS_GATE, d);
		reg_wr(clk_ctrl_pkg::OFS_WDO_CTRL, d);
		reg_wr(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0002);
		reg_wr(clk_ctrl_pkg::OFS_CORE_DIV, 16'h0003);
		settle();
		check(32'(periph_clk_en), 32'(d));
		check(32'(wdo_trim), 32'(d[8:0]));
		reg_rd(clk_ctrl_pkg::OFS_GATE, d);
		reg_rd(clk_ctrl_pkg::OFS_WDO_CTRL, {7'h00, d[8:0]});
		meas(4, 300, 10, 10);
		reg_wr(clk_ctrl_pkg::OFS_CORE_DIV, 16'h0000);
		settle();
		meas(4, 60, 0, 0);
		// Second reset in mid-run puts everything back on the RC source
		do_reset();
		check(32'(pll_pd), 32'h1);
		check(32'(periph_clk_en), 32'h1F);
		reg_rd(clk_ctrl_pkg::OFS_MAIN_SEL, 16'h0000);
		reg_rd(clk_ctrl_pkg::OFS_CORE_DIV, 16'h0001);
		settle();
		per(0, 6);
		repeat (3) @(posedge clk_sys);
		check(32'(exp_q.size()), 32'h0);
		report_and_stop();
	end
endmodule : testbench
